// *** hw/itr_consts.svh ***
// Constants for the serial target register-access front end
// Summary of operation
// [R1] Address is fixed 1110 plus three select bits
// [R2] Respond only when low bits match select pins
// [R3] Also accept broadcast 0000xxx, selected for writing
// [R4] Master sends write direction with broadcast address
// [R5] Direction bit zero writes, one reads
// [R6] Receiver acknowledges each correctly received byte
// [R7] Pointer byte: 000, increment bit, index 0-8
// [R8] Increment off: stay on selected register only
// [R9] Increment on: advance index after each register
// [R10] Hold index until all register bytes done
// [R11] Read increment skips transfer register, wraps after eight
// [R12] Write increment wraps to zero after five
// [R13] Multi-byte values travel most significant first
// [R14] Master not-acknowledge or stop ends the transfer
// [R15] Lost read bit releases bus until readdressed
// [R16] Start anywhere aborts and restarts address reception
// [R17] Stop anywhere aborts and returns to idle
// [R18] Master starts or stops only when line free
// [R19] Broadcast write: every device acknowledges each byte
// [R20] Unaddressed device leaves data line released
`ifndef ITR_CONSTS_SVH
`define ITR_CONSTS_SVH
`define ITR_ADDR_FIXED 4'he
`define ITR_BCAST_FIXED 4'h0
`define ITR_FIXED_FIELD 7:4
`define ITR_SELECT_FIELD 3:1
`define ITR_RW_BIT 0
`define ITR_PTR_UPPER 3'h0
`define ITR_PTR_UPPER_FIELD 7:5
`define ITR_INC_BIT 4
`define ITR_INDEX_FIELD 3:0
`define ITR_IDX_FIRST 4'h0
`define ITR_IDX_MAX 4'h8
`define ITR_READ_WRAP_IDX 4'h8
`define ITR_WRITE_WRAP_IDX 4'h5
`define ITR_SKIPPED_TRANSFER_REG_IDX 4'h3
`define ITR_LAST_BIT 3'h7
`define ITR_LINK_SYNC_WIDTH 17
`endif

// *** hw/itr_pkg.sv ***
// Types shared by the serial target front end
package itr_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK_OUT, ST_TX, ST_ACK_IN, ST_WAIT} itr_state_e;
  typedef enum logic [1:0] {RX_ADDR, RX_PTR, RX_DATA} itr_rx_e;
endpackage

// *** hw/itr_sync.sv ***
// Two-stage level synchroniser, one per bit
`timescale 1ns/100ps
module itr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

// *** hw/itr_core_port.sv ***
// Core-clock side of the register request handshake
`timescale 1ns/100ps
module itr_core_port (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reqToggle,
  input wire logic reqWrite,
  input wire logic [3:0] reqIndex,
  input wire logic [1:0] reqLane,
  input wire logic [7:0] reqData,
  input wire logic [7:0] rdData,
  output logic ackToggle,
  output logic [7:0] rdByte,
  output logic [3:0] coreIndex,
  output logic [1:0] coreLane,
  output logic [7:0] coreWrData,
  output logic coreWrStrobe,
  output logic coreRdStrobe
);
  logic reqS;
  logic reqQ;
  logic reqEdge;
  logic rdPending;

  itr_sync #(.WIDTH(1)) u_reqSync (.clock(clock), .rst_b(rst_b), .din(reqToggle), .dout(reqS));

  // Request fields change with the toggle and are held still by the link side while it crosses
  assign reqEdge = reqS ^ reqQ;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reqQ <= 1'b0;
      coreWrStrobe <= 1'b0;
      coreRdStrobe <= 1'b0;
      coreIndex <= 4'h0;
      coreLane <= 2'h0;
      coreWrData <= 8'h00;
    end else begin
      reqQ <= reqS;
      coreWrStrobe <= reqEdge & reqWrite;
      coreRdStrobe <= reqEdge & ~reqWrite;
      if (reqEdge) begin
        coreIndex <= reqIndex;
        coreLane <= reqLane;
        coreWrData <= reqData;
      end
    end
  end

  // Read data is valid one cycle after the strobe; it goes back with the toggle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdPending <= 1'b0;
      rdByte <= 8'h00;
      ackToggle <= 1'b0;
    end else begin
      rdPending <= coreRdStrobe;
      if (rdPending) begin
        rdByte <= rdData;
        ackToggle <= ~ackToggle;
      end
    end
  end

  a_write_pulse: assert property (@(posedge clock) disable iff (!rst_b)
    reqEdge && reqWrite |=> coreWrStrobe && coreWrData == $past(reqData) ##1 !coreWrStrobe)
    else $error("write request did not give one strobe");
  a_read_answer: assert property (@(posedge clock) disable iff (!rst_b)
    coreRdStrobe |=> ##1 (rdByte == $past(rdData) && ackToggle != $past(ackToggle)))
    else $error("read answer not returned two cycles after strobe");
endmodule

// *** hw/itr_target.sv ***
// Serial bus target front end: address decode, pointer walk, byte transfer
`timescale 1ns/100ps
`include "itr_consts.svh"
module itr_target
  import itr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic busSampleClock,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_b,
  input wire logic addrSelectPinHi,
  input wire logic addrSelectPinMid,
  input wire logic addrSelectPinLo,
  input wire logic [8:0] multiByteMask,
  input wire logic [1:0] regBytesM1,
  input wire logic [7:0] rdData,
  output logic [3:0] coreIndex,
  output logic [1:0] coreLane,
  output logic [7:0] coreWrData,
  output logic coreWrStrobe,
  output logic coreRdStrobe
);
  logic [`ITR_LINK_SYNC_WIDTH-1:0] rawIn;
  logic [`ITR_LINK_SYNC_WIDTH-1:0] syncIn;
  logic sclS;
  logic sdaS;
  logic [2:0] pinsS;
  logic [8:0] maskS;
  logic [1:0] bytesS;
  logic ackS;
  logic sclQ;
  logic sdaQ;
  logic ackQ;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic busCond;
  itr_state_e state;
  itr_rx_e rxKind;
  logic [2:0] bitCnt;
  logic [7:0] shiftReg;
  logic rxFull;
  logic isRead;
  logic bcast;
  logic [7:0] txByte;
  logic ackSeen;
  logic evalNow;
  logic addrMatch;
  logic addrBcast;
  logic ptrValid;
  logic advance;
  logic [3:0] regIndex;
  logic [1:0] byteNum;
  logic autoInc;
  logic [3:0] next_regIndex;
  logic [1:0] next_byteNum;
  logic next_autoInc;
  logic [1:0] curLast;
  logic [7:0] rdHold;
  logic reqToggle;
  logic reqWrite;
  logic [3:0] reqIndex;
  logic [1:0] reqLane;
  logic [7:0] reqData;
  logic ackToggle;
  logic [7:0] rdByte;

  // Last byte number of a register: multi-byte ones use the configured width
  function automatic logic [1:0] lastByteOf(input logic [3:0] idx, input logic [8:0] mask,
                                            input logic [1:0] nbytes);
    logic [1:0] res;
    res = 2'h0;
    if (idx <= `ITR_IDX_MAX) begin
      if (mask[idx]) begin
        res = nbytes;
      end
    end
    return res;
  endfunction

  // Byte lane for a byte number; byte zero is the most significant lane
  function automatic logic [1:0] laneOf(input logic [3:0] idx, input logic [1:0] num,
                                        input logic [8:0] mask, input logic [1:0] nbytes);
    logic [1:0] res;
    res = lastByteOf(idx, mask, nbytes) - num;
    return res;
  endfunction

  // Index after a finished register, per transfer direction
  function automatic logic [3:0] nextIndex(input logic [3:0] idx, input logic rd);
    logic [3:0] res;
    res = idx + 4'h1;
    if (rd) begin
      if (idx >= `ITR_READ_WRAP_IDX) begin
        res = `ITR_IDX_FIRST;
      end else if (res == `ITR_SKIPPED_TRANSFER_REG_IDX) begin
        res = idx + 4'h2;
      end
    end else if (idx >= `ITR_WRITE_WRAP_IDX) begin
      res = `ITR_IDX_FIRST;
    end
    return res;
  endfunction

  // Pins, static configuration and the answer toggle all cross into the link domain
  assign rawIn = {ackToggle, regBytesM1, multiByteMask, addrSelectPinHi, addrSelectPinMid,
                  addrSelectPinLo, sdaIn, scl};

  itr_sync #(.WIDTH(`ITR_LINK_SYNC_WIDTH)) u_linkSync (
    .clock(busSampleClock),
    .rst_b(rst_b),
    .din(rawIn),
    .dout(syncIn)
  );

  assign sclS = syncIn[0];
  assign sdaS = syncIn[1];
  assign pinsS = syncIn[4:2];
  assign maskS = syncIn[13:5];
  assign bytesS = syncIn[15:14];
  assign ackS = syncIn[16];

  // Previous synchronised levels for edge and condition detection
  always_ff @(posedge busSampleClock or negedge rst_b) begin
    if (!rst_b) begin
      sclQ <= 1'b0;
      sdaQ <= 1'b0;
      ackQ <= 1'b0;
    end else begin
      sclQ <= sclS;
      sdaQ <= sdaS;
      ackQ <= ackS;
    end
  end

  // Start and stop are data edges while the clock stays high
  assign sclRise = sclS & ~sclQ;
  assign sclFall = ~sclS & sclQ;
  assign startDet = sclS & sclQ & sdaQ & ~sdaS;
  assign stopDet = sclS & sclQ & ~sdaQ & sdaS;
  assign busCond = startDet | stopDet;

  // Byte decisions are taken at the falling clock after the eighth bit
  assign evalNow = (state == ST_RX) && sclFall && rxFull && !busCond;
  assign addrMatch = (shiftReg[`ITR_FIXED_FIELD] == `ITR_ADDR_FIXED) && // R1
                     (shiftReg[`ITR_SELECT_FIELD] == pinsS); // R2
  // Broadcast only answers in write direction; a read there is left alone
  assign addrBcast = (shiftReg[`ITR_FIXED_FIELD] == `ITR_BCAST_FIXED) && // R3
                     !shiftReg[`ITR_RW_BIT]; // R4
  assign ptrValid = (shiftReg[`ITR_PTR_UPPER_FIELD] == `ITR_PTR_UPPER) && // R7
                    (shiftReg[`ITR_INDEX_FIELD] <= `ITR_IDX_MAX);
  // Pointer moves after each written byte and each master-acknowledged read byte
  assign advance = (evalNow && rxKind == RX_DATA) ||
                   (state == ST_ACK_IN && sclRise && !sdaS && !busCond);
  assign curLast = lastByteOf(regIndex, maskS, bytesS);

  // Pointer walk
  always_comb begin
    next_regIndex = regIndex;
    next_byteNum = byteNum;
    next_autoInc = autoInc;
    if (evalNow && rxKind == RX_PTR && ptrValid) begin
      next_regIndex = shiftReg[`ITR_INDEX_FIELD]; // R7
      next_autoInc = shiftReg[`ITR_INC_BIT];
      next_byteNum = 2'h0;
    end else if (advance) begin
      if (byteNum != curLast) begin
        next_byteNum = byteNum + 2'h1; // R10
      end else begin
        next_byteNum = 2'h0; // R8
        if (autoInc) begin
          next_regIndex = nextIndex(regIndex, isRead); // R9 R11 R12
        end
      end
    end
  end

  // Pointer survives a repeated start so a read can follow the pointer write
  always_ff @(posedge busSampleClock or negedge rst_b) begin
    if (!rst_b) begin
      regIndex <= `ITR_IDX_FIRST;
      byteNum <= 2'h0;
      autoInc <= 1'b0;
    end else begin
      regIndex <= next_regIndex;
      byteNum <= next_byteNum;
      autoInc <= next_autoInc;
    end
  end

  // Requests to the core; fields settle with the toggle and stay until the next one
  always_ff @(posedge busSampleClock or negedge rst_b) begin
    if (!rst_b) begin
      reqToggle <= 1'b0;
      reqWrite <= 1'b0;
      reqIndex <= 4'h0;
      reqLane <= 2'h0;
      reqData <= 8'h00;
    end else if (evalNow && rxKind == RX_DATA) begin
      reqToggle <= ~reqToggle;
      reqWrite <= 1'b1;
      reqIndex <= regIndex;
      reqLane <= laneOf(regIndex, byteNum, maskS, bytesS); // R13
      reqData <= shiftReg;
    end else if (evalNow && rxKind == RX_ADDR && addrMatch && shiftReg[`ITR_RW_BIT]) begin
      reqToggle <= ~reqToggle; // R5
      reqWrite <= 1'b0;
      reqIndex <= regIndex;
      reqLane <= laneOf(regIndex, byteNum, maskS, bytesS); // R13
    end else if (advance && isRead) begin
      // Fetch ahead during the acknowledge so the byte is ready by the next fall
      reqToggle <= ~reqToggle;
      reqWrite <= 1'b0;
      reqIndex <= next_regIndex;
      reqLane <= laneOf(next_regIndex, next_byteNum, maskS, bytesS); // R13
    end
  end

  // Read byte arrives under the returned toggle, already stable
  always_ff @(posedge busSampleClock or negedge rst_b) begin
    if (!rst_b) begin
      rdHold <= 8'h00;
    end else if (ackS != ackQ) begin
      rdHold <= rdByte;
    end
  end

  // Line is open drain: only ever pulled low
  always_ff @(posedge busSampleClock or negedge rst_b) begin
    if (!rst_b) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // Bus state machine; start and stop override every state
  always_ff @(posedge busSampleClock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      rxKind <= RX_ADDR;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      rxFull <= 1'b0;
      isRead <= 1'b0;
      bcast <= 1'b0;
      txByte <= 8'h00;
      ackSeen <= 1'b0;
      sdaOe_b <= 1'b1;
    end else if (startDet) begin
      state <= ST_RX; // R16
      rxKind <= RX_ADDR;
      bitCnt <= 3'h0;
      rxFull <= 1'b0;
      sdaOe_b <= 1'b1;
    end else if (stopDet) begin
      state <= ST_IDLE; // R17
      rxFull <= 1'b0;
      sdaOe_b <= 1'b1;
    end else begin
      case (state)
        ST_RX: begin
          if (sclRise) begin
            shiftReg <= {shiftReg[6:0], sdaS};
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == `ITR_LAST_BIT) begin
              rxFull <= 1'b1;
            end
          end else if (evalNow) begin
            rxFull <= 1'b0;
            case (rxKind)
              RX_ADDR: begin
                if (addrMatch || addrBcast) begin
                  state <= ST_ACK_OUT;
                  sdaOe_b <= 1'b0; // R6 R19
                  isRead <= shiftReg[`ITR_RW_BIT]; // R5
                  bcast <= addrBcast;
                end else begin
                  state <= ST_WAIT; // R20
                end
              end
              RX_PTR: begin
                // An out-of-range pointer is refused with no acknowledge
                if (ptrValid) begin
                  state <= ST_ACK_OUT;
                  sdaOe_b <= 1'b0; // R6
                end else begin
                  state <= ST_WAIT;
                end
              end
              default: begin
                state <= ST_ACK_OUT;
                sdaOe_b <= 1'b0; // R6 R19
              end
            endcase
          end
        end
        ST_ACK_OUT: begin
          if (sclFall) begin
            bitCnt <= 3'h0;
            if (isRead) begin
              state <= ST_TX;
              txByte <= rdHold;
              sdaOe_b <= rdHold[7]; // R13
            end else begin
              state <= ST_RX;
              rxKind <= (rxKind == RX_ADDR) ? RX_PTR : RX_DATA;
              sdaOe_b <= 1'b1;
            end
          end
        end
        ST_TX: begin
          if (sclRise && sdaOe_b && !sdaS) begin
            state <= ST_WAIT; // R15
          end else if (sclFall) begin
            if (bitCnt == `ITR_LAST_BIT) begin
              state <= ST_ACK_IN;
              ackSeen <= 1'b0;
              sdaOe_b <= 1'b1;
            end else begin
              bitCnt <= bitCnt + 3'h1;
              txByte <= {txByte[6:0], 1'b0};
              sdaOe_b <= txByte[6];
            end
          end
        end
        ST_ACK_IN: begin
          if (sclRise) begin
            if (sdaS) begin
              state <= ST_WAIT; // R14
            end else begin
              ackSeen <= 1'b1;
            end
          end else if (sclFall && ackSeen) begin
            state <= ST_TX;
            bitCnt <= 3'h0;
            txByte <= rdHold;
            sdaOe_b <= rdHold[7];
          end
        end
        default: begin
          // Idle or ignoring the rest of a transfer: line stays released
          sdaOe_b <= 1'b1; // R14 R20
        end
      endcase
    end
  end

  itr_core_port u_corePort (
    .clock(clock),
    .rst_b(rst_b),
    .reqToggle(reqToggle),
    .reqWrite(reqWrite),
    .reqIndex(reqIndex),
    .reqLane(reqLane),
    .reqData(reqData),
    .rdData(rdData),
    .ackToggle(ackToggle),
    .rdByte(rdByte),
    .coreIndex(coreIndex),
    .coreLane(coreLane),
    .coreWrData(coreWrData),
    .coreWrStrobe(coreWrStrobe),
    .coreRdStrobe(coreRdStrobe)
  );

  default clocking cbLink @(posedge busSampleClock);
  endclocking
  default disable iff (!rst_b);

  a_addr_match: assert property ( // R2
    evalNow && rxKind == RX_ADDR && addrMatch |=> state == ST_ACK_OUT && !sdaOe_b)
    else $error("matching address not acknowledged");
  a_addr_ignore: assert property ( // R20
    evalNow && rxKind == RX_ADDR && !addrMatch && !addrBcast |=> state == ST_WAIT && sdaOe_b)
    else $error("unmatched address did not release the line");
  a_bcast_ack: assert property ( // R3
    evalNow && rxKind == RX_ADDR && addrBcast |=> !sdaOe_b && bcast)
    else $error("broadcast address not acknowledged");
  a_start_restart: assert property ( // R16
    startDet |=> state == ST_RX && rxKind == RX_ADDR && bitCnt == 3'h0 && sdaOe_b)
    else $error("start did not restart address reception");
  a_stop_idle: assert property ( // R17
    stopDet |=> state == ST_IDLE && sdaOe_b)
    else $error("stop did not return to idle");
  a_nack_ends: assert property ( // R14
    state == ST_ACK_IN && sclRise && sdaS && !busCond |=> state == ST_WAIT [*2])
    else $error("master not-acknowledge did not end transfer");
  a_arb_release: assert property ( // R15
    state == ST_TX && sclRise && sdaOe_b && !sdaS && !busCond |=> sdaOe_b && state == ST_WAIT)
    else $error("lost bit did not release the bus");
  a_ptr_load: assert property ( // R7
    evalNow && rxKind == RX_PTR && ptrValid |=>
      regIndex == $past(shiftReg[3:0]) && autoInc == $past(shiftReg[4]) && byteNum == 2'h0)
    else $error("pointer byte not loaded");
  a_hold_multi: assert property ( // R10
    advance && byteNum != curLast |=> regIndex == $past(regIndex) && byteNum == $past(byteNum) + 2'h1)
    else $error("index moved inside a multi-byte register");
  a_write_wrap: assert property ( // R12
    advance && !isRead && autoInc && byteNum == curLast && regIndex == `ITR_WRITE_WRAP_IDX
      |=> regIndex == `ITR_IDX_FIRST)
    else $error("write index did not wrap after five");
  a_read_skip: assert property ( // R11
    advance && isRead && autoInc && byteNum == curLast &&
      regIndex == `ITR_SKIPPED_TRANSFER_REG_IDX - 4'h1 |=> regIndex == `ITR_SKIPPED_TRANSFER_REG_IDX + 4'h1)
    else $error("read walk did not skip the transfer register");
  a_read_wrap: assert property ( // R11
    advance && isRead && autoInc && byteNum == curLast && regIndex == `ITR_READ_WRAP_IDX
      |=> regIndex == `ITR_IDX_FIRST)
    else $error("read index did not wrap after eight");
  a_fixed_index: assert property ( // R8
    advance && !autoInc |=> regIndex == $past(regIndex))
    else $error("index moved with increment off");

  c_bcast_write: cover property (evalNow && rxKind == RX_DATA && bcast);
  c_read_byte: cover property (state == ST_ACK_IN && sclRise && !sdaS);
  c_arb_lost: cover property (state == ST_TX && sclRise && sdaOe_b && !sdaS);
  c_multi_write: cover property (advance && !isRead && byteNum != curLast);
endmodule

// *** tb/itr_bus_master.sv ***
// Behavioural serial bus master that drives the bus clock and pulls the data line
`timescale 1ns/100ps
module itr_bus_master #(
  parameter int HALF = 250
) (
  output logic scl,
  output logic sdaPull,
  input wire logic sda
);
  // Idle bus: clock high, data released; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end

  // One bit: data changes only while the clock is low, sampled late in the high phase
  task automatic bitIo(input logic b, output logic r);
    #(HALF / 4) sdaPull = !b;
    #(HALF - HALF / 4) scl = 1'b1;
    #(HALF) r = sda;
    scl = 1'b0;
  endtask

  // Released line first, so a start never fights a low from the device
  task automatic start();
    #(HALF / 4) sdaPull = 1'b0;
    #(HALF) scl = 1'b1;
    #(HALF) sdaPull = 1'b1;
    #(HALF) scl = 1'b0;
  endtask

  // Stop ends the frame and leaves the bus idle
  task automatic stop();
    #(HALF / 4) sdaPull = 1'b1;
    #(HALF) scl = 1'b1;
    #(HALF) sdaPull = 1'b0;
    #(HALF);
  endtask

  // Byte out, most significant bit first, then sample the acknowledge
  task automatic wrByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitIo(b[i], ack);
    end
    bitIo(1'b1, ack);
  endtask

  // Byte in; pull marks bits forced low to provoke a lost bit, nack ends the read
  task automatic rdByte(input logic [7:0] pull, input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitIo(!pull[i], r);
      d[i] = r;
    end
    bitIo(nack, r);
  endtask
endmodule

// *** tb/itr_target_bench.sv ***
// Self-checking bench for the serial target front end
`timescale 1ns/100ps
module itr_target_bench;
  import itr_pkg::*;
  logic clock = 1'b0;
  logic busSampleClock = 1'b0;
  logic rst_b = 1'b0;
  logic scl;
  logic sdaPull;
  logic sdaOut;
  logic sdaOe_b;
  wire logic sda;
  logic [7:0] rdData = 8'h00;
  logic [3:0] coreIndex;
  logic [1:0] coreLane;
  logic [7:0] coreWrData;
  logic coreWrStrobe;
  logic coreRdStrobe;
  logic [13:0] wrQ[$];
  logic a;
  logic [7:0] d;
  int nErrors = 0;
  int compares = 0;
  int nRd = 0;

  always #2.5 clock = ~clock;
  always #24 busSampleClock = ~busSampleClock;

  // Open-drain wire with pull-up: low if either party pulls
  assign sda = (sdaOe_b ? 1'b1 : sdaOut) & !sdaPull;

  itr_bus_master m (.scl(scl), .sdaPull(sdaPull), .sda(sda));

  // Pins select 101; registers 2 and 8 are two bytes wide
  itr_target dut (.clock(clock), .rst_b(rst_b), .busSampleClock(busSampleClock), .scl(scl),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .addrSelectPinHi(1'b1),
    .addrSelectPinMid(1'b0), .addrSelectPinLo(1'b1), .multiByteMask(9'h104),
    .regBytesM1(2'h1), .rdData(rdData), .coreIndex(coreIndex), .coreLane(coreLane),
    .coreWrData(coreWrData), .coreWrStrobe(coreWrStrobe), .coreRdStrobe(coreRdStrobe));

  // Core model: read byte is index and lane, so the walk shows in the data
  always @(negedge clock) begin
    rdData <= {coreIndex, 2'h0, coreLane};
  end

  // Collect writes and count reads mid-cycle, away from the edge that launches the strobes
  always @(negedge clock) begin
    if (coreWrStrobe === 1'b1) begin
      wrQ.push_back({coreIndex, coreLane, coreWrData});
    end
    if (coreRdStrobe === 1'b1) begin
      nRd++;
    end
  end

  task automatic fail(input string s);
    nErrors++;
    $display("[FAIL] %0t %s", $time, s);
  endtask

  task automatic chkAck(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail("acknowledge mismatch");
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail("read byte mismatch");
  endtask

  task automatic chkWr(input logic [3:0] idx, input logic [1:0] lane, input logic [7:0] dat);
    compares++;
    if (wrQ.size() == 0) fail("write missing");
    else if (wrQ.pop_front() !== {idx, lane, dat}) fail("write mismatch");
  endtask

  task automatic chkRd(input int exp);
    compares++;
    if (nRd != exp) fail("read strobe count mismatch");
  endtask

  task automatic chkNoWr();
    compares++;
    if (wrQ.size() != 0) fail("unexpected write");
    wrQ.delete();
  endtask

  task automatic sendB(input logic [7:0] b, input logic expAck);
    m.wrByte(b, a);
    chkAck(a, expAck);
  endtask

  task automatic rdB(input logic [7:0] pull, input logic nack, input logic [7:0] exp);
    m.rdByte(pull, nack, d);
    chkByte(d, exp);
  endtask

  // Single exit point for both the normal end and the watchdog
  task automatic conclude();
    $display("compares=%0d nErrors=%0d", compares, nErrors);
    if (nErrors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected run is about 206 us; the margin covers slow acknowledges
  initial begin
    #450000;
    fail("watchdog expired");
    conclude();
  end

  initial begin
    // Reset spans enough link edges to flush both synchronisers
    repeat (6) @(posedge busSampleClock);
    @(negedge clock) rst_b = 1'b1;
    repeat (4) @(posedge busSampleClock);
    // Incrementing write wraps after index 5
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h14, 1'b0);
    sendB(8'h11, 1'b0);
    sendB(8'h22, 1'b0);
    sendB(8'h33, 1'b0);
    m.stop();
    chkWr(4'h4, 2'h0, 8'h11);
    chkWr(4'h5, 2'h0, 8'h22);
    chkWr(4'h0, 2'h0, 8'h33);
    // Two-byte register: index held, most significant byte first
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h12, 1'b0);
    sendB(8'haa, 1'b0);
    sendB(8'hbb, 1'b0);
    sendB(8'hcc, 1'b0);
    m.stop();
    chkWr(4'h2, 2'h1, 8'haa);
    chkWr(4'h2, 2'h0, 8'hbb);
    chkWr(4'h3, 2'h0, 8'hcc);
    // Broadcast write, increment off then repeated access
    m.start();
    sendB(8'h06, 1'b0);
    sendB(8'h01, 1'b0);
    sendB(8'h5c, 1'b0);
    sendB(8'h77, 1'b0);
    m.stop();
    chkWr(4'h1, 2'h0, 8'h5c);
    chkWr(4'h1, 2'h0, 8'h77);
    // Refused: other device, bad pointers, broadcast read
    m.start();
    sendB(8'he6, 1'b1);
    m.stop();
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h09, 1'b1);
    m.stop();
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h21, 1'b1);
    m.stop();
    m.start();
    sendB(8'h07, 1'b1);
    m.stop();
    chkNoWr();
    // Start inside a byte restarts address reception
    m.start();
    sendB(8'hea, 1'b0);
    repeat (3) m.bitIo(1'b1, a);
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h01, 1'b0);
    sendB(8'h66, 1'b0);
    m.stop();
    chkWr(4'h1, 2'h0, 8'h66);
    // Stop inside a data byte drops it; the pointer survives
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h18, 1'b0);
    repeat (4) m.bitIo(1'b0, a);
    m.stop();
    chkNoWr();
    m.start();
    sendB(8'heb, 1'b0);
    rdB(8'h00, 1'b0, 8'h81);
    rdB(8'h00, 1'b0, 8'h80);
    rdB(8'h00, 1'b1, 8'h00);
    m.stop();
    // Lost bit: device releases for the rest of the byte
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h14, 1'b0);
    m.start();
    sendB(8'heb, 1'b0);
    rdB(8'h40, 1'b1, 8'h3f);
    m.stop();
    // Read walk skips the transfer register
    m.start();
    sendB(8'hea, 1'b0);
    sendB(8'h12, 1'b0);
    m.start();
    sendB(8'heb, 1'b0);
    rdB(8'h00, 1'b0, 8'h21);
    rdB(8'h00, 1'b0, 8'h20);
    rdB(8'h00, 1'b1, 8'h40);
    m.stop();
    chkNoWr();
    // Address read plus one fetch per master acknowledge: 3 + 1 + 3
    chkRd(7);
    conclude();
  end
endmodule
